// [spf_defines.vh]
// Register map, field positions, reset values and sizes of the serial port
`ifndef SPF_DEFINES_VH
`define SPF_DEFINES_VH

// Word index of each register (byte address is four times the index)
`define SPF_IDX_STAT      3'h0
`define SPF_IDX_CON1      3'h1
`define SPF_IDX_CON2      3'h2
`define SPF_IDX_DATA      3'h3
`define SPF_IDX_IRQ_ST    3'h4
`define SPF_IDX_IRQ_MSK   3'h5

// status_control_reg fields
`define SPF_ST_ON         15
`define SPF_ST_IDLE_HALT  13
`define SPF_ST_ISEL_LO    2
`define SPF_ST_OVF        6

// control_reg_one fields, stored as a 13-bit vector
`define SPF_C1_DIS_SCK    12
`define SPF_C1_DIS_SDO    11
`define SPF_C1_MODE16     10
`define SPF_C1_SMP        9
`define SPF_C1_CKE        8
`define SPF_C1_SELECT_PIN_ENABLE       7
`define SPF_C1_CKP        6
`define SPF_C1_MASTER_SELECT      5
`define SPF_C1_W          13

// control_reg_two fields
`define SPF_C2_FRMEN      15
`define SPF_C2_FRMDIR     14
`define SPF_C2_FRMPOL     13
`define SPF_C2_FRMEDGE    1
`define SPF_C2_FIFOEN     0

// Interrupt status bits: word done, overflow, transmit slot freed
`define SPF_IRQ_DONE      0
`define SPF_IRQ_OVF       1
`define SPF_IRQ_TXFREE    2
`define SPF_IRQ_W         3

// Reset values
`define SPF_RST_C1        13'h0000
`define SPF_RST_IRQ       3'h0

// Enhanced buffer depth and its pointer width
`define SPF_FIFO_DEPTH    8
`define SPF_FIFO_AW       3

`endif

// [spf_fifo.v]
// Flip-flop FIFO used for both the transmit and the receive path
`timescale 1ns/1ps
module spf_fifo #(
  parameter W     = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire          clk_i,
  input  wire          arst_n_i,
  input  wire          clr_i,
  input  wire          push_i,
  input  wire [W-1:0]  data_i,
  input  wire          pop_i,
  output wire [W-1:0]  head_o,
  output wire [AW:0]   count_o
);
  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wp;
  reg [AW-1:0] rp;
  reg [AW:0]   cnt;
  integer      k;

  assign head_o  = mem[rp];
  assign count_o = cnt;

  // Caller guards push against full and pop against empty
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
      for (k = 0; k < DEPTH; k = k + 1)
        mem[k] <= {W{1'b0}};
    end
    else if (clr_i)
    begin
      wp  <= {AW{1'b0}};
      rp  <= {AW{1'b0}};
      cnt <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push_i)
      begin
        mem[wp] <= data_i;
        wp      <= wp + 1'b1;
      end
      if (pop_i)
        rp <= rp + 1'b1;
      if (push_i && !pop_i)
        cnt <= cnt + 1'b1;
      else if (pop_i && !push_i)
        cnt <= cnt - 1'b1;
    end
  end
endmodule // spf_fifo

// [spf_peer_model.sv]
// Echoing serial peer: shifts back what it received on the previous word
`timescale 1ns/1ps
module spf_peer_model #(
  parameter [7:0] INIT = 8'h5A
) (
  input  wire       sck_i,
  input  wire       sdo_i,
  output wire       sdi_o,
  output wire [7:0] data_o
);
  reg [7:0] sr    = INIT;
  reg       sck_q = 1'b0;

  // MSB first; capture and shift together at the trailing edge
  assign sdi_o  = sr[7];
  assign data_o = sr;
  // Only a true one-to-zero step shifts, so the unknown-to-zero step of
  // the clock at power-up does not push a stray bit in
  always @(sck_i)
  begin
    if (sck_q === 1'b1 && sck_i === 1'b0)
      sr <= {sr[6:0], sdo_i};
    sck_q = sck_i;
  end
endmodule // spf_peer_model

// [spf_top.v]
// Serial port with single buffer or FIFO, master or slave, framed modes
// How it works
// RQ1: One-word buffer, or eight-entry FIFO when enabled
// RQ2: Output and select pins can be switched off
// RQ3: Framed pulse: master or slave, in or out
// RQ4: Master starts shifting once data is written
// RQ5: Slave with edge select needs select pin
// RQ6: Module-on claims pins; off disables everything
// RQ7: Idle-halt freezes the port during system idle
// RQ8: Count shows pending tx or unread rx words
// RQ9: Word arriving into full receive sets overflow
// RQ10: Single mode: tx full until moved to shifter
// RQ11: FIFO mode: tx full while no entry free
// RQ12: Single mode: rx full until data read
// RQ13: FIFO mode: rx full while no entry free
// RQ14: Software never read-modify-writes the data window
// RQ15: Master setup order ends with module-on
// RQ16: Slave setup clears data first, module-on last
// RQ17: Clock is input clock over primary times secondary; code gives two clocks for one and one less for odd products
// RQ18: Secondary divider 111 is one, 000 eight
// RQ19: Most significant bit first, full duplex
`timescale 1ns/1ps
`include "spf_defines.vh"
module spf_top #(
  parameter DEPTH = `SPF_FIFO_DEPTH,
  parameter AW    = `SPF_FIFO_AW
) (
  input  wire        clk_i,
  input  wire        arst_n_i,
  input  wire [4:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  output reg         irq_o,
  input  wire        idle_i,
  input  wire        sck_i,
  output reg         sck_o,
  output reg         sck_oe_o,
  input  wire        sdi_i,
  output reg         sdo_o,
  output reg         sdo_oe_o,
  input  wire        ss_i,
  output reg         ss_o,
  output reg         ss_oe_o
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_PRE   = 2'b01;
  localparam ST_SHIFT = 2'b10;

  reg                module_on;
  reg                idle_halt;
  reg  [2:0]         isel;
  reg                ovf;
  reg  [`SPF_C1_W-1:0] con1;
  reg                frmen, frmdir, frmpol, frmedge, fifoen;
  reg  [`SPF_IRQ_W-1:0] irq_st, irq_msk;
  reg  [1:0]         state;
  reg  [8:0]         dcnt;
  reg  [4:0]         tcnt;
  reg  [4:0]         bcnt;
  reg  [15:0]        sr;
  reg                samp;
  reg                loaded;
  reg                armed;
  reg                sck_q;
  reg                on_q;

  wire [15:0] tx_head, rx_head;
  wire [AW:0] tx_cnt, rx_cnt;

  // Bus decode; an access completes on the cycle waitrequest is low
  wire [2:0]  idx    = avs_address_i[4:2];
  wire        acc_wr = avs_write_i & ~avs_waitrequest_o;
  wire        acc_rd = avs_read_i & ~avs_waitrequest_o;
  wire [15:0] wmask  = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [15:0] wd     = avs_writedata_i[15:0];
  wire        wr_any = acc_wr & (|avs_byteenable_i[1:0]);

  // Configuration fields
  wire master = con1[`SPF_C1_MASTER_SELECT];
  wire ckp    = con1[`SPF_C1_CKP];
  wire cke    = con1[`SPF_C1_CKE];
  wire sample_phase    = con1[`SPF_C1_SMP];
  wire m16    = con1[`SPF_C1_MODE16];
  wire select_pin_enable   = con1[`SPF_C1_SELECT_PIN_ENABLE];
  wire [2:0] secondary_divider = con1[4:2];
  wire [1:0] primary_divider = con1[1:0];

  // Halting in idle freezes clocking and shifting alike
  wire run = module_on & ~(idle_halt & idle_i);        // see RQ7

  // Primary 11/10/01/00 = 1/4/16/64, secondary 111..000 = 1..8
  wire [6:0] p_div = 7'd1 << {~primary_divider, 1'b0};            // see RQ17
  wire [3:0] s_div = {1'b0, ~secondary_divider} + 4'd1;             // see RQ18
  wire [9:0] d_tot = {3'b000, p_div} * {6'b000000, s_div};
  // Divide by one cannot be halved, so it runs at half the clock rate
  wire [8:0] half  = (d_tot[9:1] == 9'd0) ? 9'd1 : d_tot[9:1];
  wire       tick  = run & (state != ST_IDLE) & (dcnt == half - 9'd1);

  // Buffer capacity: one word in single mode, DEPTH in FIFO mode
  wire [AW:0] cap     = fifoen ? DEPTH[AW:0] : {{AW{1'b0}}, 1'b1};
  wire        tx_full = (tx_cnt >= cap);                // see RQ10 RQ11
  wire        rx_full = (rx_cnt >= cap);                // see RQ12 RQ13
  wire        tx_avl  = (tx_cnt != {(AW+1){1'b0}});
  wire        rx_avl  = (rx_cnt != {(AW+1){1'b0}});

  // Framed pulse detection on the select/frame pin
  wire sync_in = frmen & frmdir;                        // see RQ3
  wire ss_act  = (ss_i == frmpol);
  wire sel     = frmen ? (~frmdir | armed)
                       : (~select_pin_enable | ~ss_i);               // see RQ5

  // Edge pulses from the own divider or from the peer's clock
  wire s_chg   = ~master & run & sel & (sck_i != sck_q);
  wire lead    = (master & tick & (state == ST_SHIFT) & ~tcnt[0])
               | (s_chg & (sck_i != ckp));
  wire trail   = (master & tick & (state == ST_SHIFT) & tcnt[0])
               | (s_chg & (sck_i == ckp));

  // Bit order: the word's top bit goes out first
  wire [4:0]  bits   = m16 ? 5'd16 : 5'd8;
  wire        sr_top = m16 ? sr[15] : sr[7];            // see RQ19
  wire        sr_nxt = m16 ? sr[14] : sr[6];
  wire        late   = master & sample_phase & cke;
  wire        in_bit = (cke & ~late) ? samp : sdi_i;
  wire [15:0] sr_sh  = {sr[14:0], in_bit};
  wire [15:0] rx_w   = m16 ? sr_sh : {8'h00, sr_sh[7:0]};
  wire        last   = (bcnt == bits - 5'd1);
  wire        done   = trail & last;

  // Loading the shifter empties the transmit slot it came from
  wire can_ld = ~loaded & tx_avl & run &
                (master ? (state == ST_IDLE) : (bcnt == 5'd0 & ~s_chg));
  wire tx_pop = can_ld;                                 // see RQ10 RQ11
  wire tx_psh = wr_any & (idx == `SPF_IDX_DATA) & ~tx_full;
  // A word completing into a full receive side is dropped
  wire rx_psh = done & ~rx_full;                        // see RQ9
  wire ovf_ev = done & rx_full;                         // see RQ9
  wire rx_pop = acc_rd & (idx == `SPF_IDX_DATA) & rx_avl; // see RQ12 RQ13
  wire clr    = on_q & ~module_on;                      // see RQ6

  // Element count saturates at seven in its three bits
  wire [AW:0] ec_raw = master ? tx_cnt : rx_cnt;        // see RQ8
  wire [2:0]  ecount = (ec_raw > 7) ? 3'd7 : ec_raw[2:0];

  wire [`SPF_IRQ_W-1:0] irq_ev = {tx_pop, ovf_ev, done};
  wire [`SPF_IRQ_W-1:0] next_irq_st =
      (irq_st & ~{`SPF_IRQ_W{acc_rd & (idx == `SPF_IDX_IRQ_ST)}}) | irq_ev;

  wire fr_pulse = master ? ((state == ST_PRE) |
                            (state == ST_SHIFT & bcnt == 5'd0 & frmedge))
                         : (loaded & bcnt == 5'd0);

  spf_fifo #(.W(16), .DEPTH(DEPTH), .AW(AW)) u_tx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .clr_i    (clr),
    .push_i   (tx_psh),
    .data_i   (wd),
    .pop_i    (tx_pop),
    .head_o   (tx_head),
    .count_o  (tx_cnt)
  );

  spf_fifo #(.W(16), .DEPTH(DEPTH), .AW(AW)) u_rx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .clr_i    (clr),
    .push_i   (rx_psh),
    .data_i   (rx_w),
    .pop_i    (rx_pop),
    .head_o   (rx_head),
    .count_o  (rx_cnt)
  );

  // Read mux; unmapped words read zero
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (idx)
      `SPF_IDX_STAT:
        rd_mux = {16'h0000, module_on, 1'b0, idle_halt, 2'b00, ecount,
                  ~loaded, ovf, ~rx_avl, isel, tx_full, rx_full};
      `SPF_IDX_CON1:    rd_mux = {19'h0_0000, con1};
      `SPF_IDX_CON2:
        rd_mux = {16'h0000, frmen, frmdir, frmpol, 11'h000, frmedge,
                  fifoen};
      `SPF_IDX_DATA:
        rd_mux = {16'h0000, m16 ? rx_head[15:8] : 8'h00, rx_head[7:0]};
      `SPF_IDX_IRQ_ST:  rd_mux = {29'h0000_0000, irq_st};
      `SPF_IDX_IRQ_MSK: rd_mux = {29'h0000_0000, irq_msk};
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave: one wait cycle, read data captured for the answer cycle
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end
    else
    begin
      if (!avs_waitrequest_o)
        avs_waitrequest_o <= 1'b1;
      else if (avs_read_i | avs_write_i)
        avs_waitrequest_o <= 1'b0;
      if (avs_read_i & avs_waitrequest_o)
        avs_readdata_o <= rd_mux;
    end
  end

  // Software registers; a hardware overflow beats a clearing write
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      module_on <= 1'b0;
      idle_halt <= 1'b0;
      isel      <= 3'b000;
      ovf       <= 1'b0;
      con1      <= `SPF_RST_C1;
      frmen     <= 1'b0;
      frmdir    <= 1'b0;
      frmpol    <= 1'b0;
      frmedge   <= 1'b0;
      fifoen    <= 1'b0;
      irq_msk   <= `SPF_RST_IRQ;
      irq_st    <= `SPF_RST_IRQ;
      irq_o     <= 1'b0;
      on_q      <= 1'b0;
    end
    else
    begin
      on_q   <= module_on;
      irq_st <= next_irq_st;
      irq_o  <= |(next_irq_st & irq_msk);
      if (wr_any & (idx == `SPF_IDX_STAT))
      begin
        if (wmask[`SPF_ST_ON])
          module_on <= wd[`SPF_ST_ON];                  // see RQ6
        if (wmask[`SPF_ST_IDLE_HALT])
          idle_halt <= wd[`SPF_ST_IDLE_HALT];           // see RQ7
        if (wmask[0])
          isel <= wd[`SPF_ST_ISEL_LO+2:`SPF_ST_ISEL_LO];
      end
      if (ovf_ev)
        ovf <= 1'b1;                                    // see RQ9
      else if (wr_any & (idx == `SPF_IDX_STAT) & wmask[`SPF_ST_OVF] &
               ~wd[`SPF_ST_OVF])
        ovf <= 1'b0;
      if (wr_any & (idx == `SPF_IDX_CON1))
        con1 <= (con1 & ~wmask[`SPF_C1_W-1:0]) |
                (wd[`SPF_C1_W-1:0] & wmask[`SPF_C1_W-1:0]);
      if (wr_any & (idx == `SPF_IDX_CON2))
      begin
        if (wmask[15])
        begin
          frmen  <= wd[`SPF_C2_FRMEN];
          frmdir <= wd[`SPF_C2_FRMDIR];
          frmpol <= wd[`SPF_C2_FRMPOL];
        end
        if (wmask[0])
        begin
          frmedge <= wd[`SPF_C2_FRMEDGE];
          fifoen  <= wd[`SPF_C2_FIFOEN];                // see RQ1
        end
      end
      if (wr_any & (idx == `SPF_IDX_IRQ_MSK) & wmask[0])
        irq_msk <= wd[`SPF_IRQ_W-1:0];
    end
  end

  // Shift engine and master clock sequencer
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state  <= ST_IDLE;
      dcnt   <= 9'd0;
      tcnt   <= 5'd0;
      bcnt   <= 5'd0;
      sr     <= 16'h0000;
      samp   <= 1'b0;
      loaded <= 1'b0;
      armed  <= 1'b0;
      sck_q  <= 1'b0;
      sck_o  <= 1'b0;
      sdo_o  <= 1'b0;
    end
    else if (!module_on)
    begin
      state  <= ST_IDLE;
      dcnt   <= 9'd0;
      tcnt   <= 5'd0;
      bcnt   <= 5'd0;
      loaded <= 1'b0;
      armed  <= 1'b0;
      sck_q  <= sck_i;
      sck_o  <= ckp;
    end
    else
    begin
      if (run)
        sck_q <= sck_i;
      if (run & (state != ST_IDLE))
        dcnt <= tick ? 9'd0 : dcnt + 9'd1;
      // A framed slave waits for the peer's pulse before counting
      if (sync_in & ~master & bcnt == 5'd0 & ss_act)
        armed <= 1'b1;                                  // see RQ3
      // Load presents the first bit for the trailing-edge case
      if (can_ld)
      begin
        sr     <= tx_head;
        loaded <= 1'b1;
        if (cke)
          sdo_o <= m16 ? tx_head[15] : tx_head[7];
      end
      if (lead)
      begin
        if (cke & ~late)
          samp <= sdi_i;
        if (!cke)
          sdo_o <= sr_top;                              // see RQ19
      end
      if (trail)
      begin
        sr   <= sr_sh;                                  // see RQ19
        if (cke)
          sdo_o <= sr_nxt;
        bcnt <= last ? 5'd0 : bcnt + 5'd1;
        if (last)
        begin
          loaded <= 1'b0;
          armed  <= 1'b0;
        end
      end
      case (state)
        ST_IDLE:
        begin
          sck_o <= ckp;
          tcnt  <= 5'd0;
          dcnt  <= 9'd0;
          // Start once written data reaches the shifter and, with frame input, the frame pulse is seen
          if (master & loaded & run & (~sync_in | ss_act)) // see RQ4
            state <= (frmen & ~frmdir & ~frmedge) ? ST_PRE : ST_SHIFT;
        end
        ST_PRE:
        begin
          if (tick)
          begin
            tcnt <= tcnt + 5'd1;
            if (tcnt[0])
            begin
              tcnt  <= 5'd0;
              state <= ST_SHIFT;
            end
          end
        end
        ST_SHIFT:
        begin
          if (tick)
          begin
            sck_o <= ~sck_o;                            // see RQ17
            tcnt  <= tcnt + 5'd1;
          end
          if (done | ~master)
            state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pin ownership; three- and two-pin wiring release select and data out
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sck_oe_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      ss_o     <= 1'b1;
      ss_oe_o  <= 1'b0;
    end
    else
    begin
      sck_oe_o <= module_on & master & ~con1[`SPF_C1_DIS_SCK]; // see RQ6
      sdo_oe_o <= module_on & ~con1[`SPF_C1_DIS_SDO] &
                  (master | frmen | ~select_pin_enable | ~ss_i);     // see RQ2
      ss_oe_o  <= module_on & frmen & ~frmdir;          // see RQ2 RQ3
      ss_o     <= fr_pulse ? frmpol : ~frmpol;
    end
  end
endmodule // spf_top

// [spf_top_props.sv]
// Property checker for the serial port, bound to its top module
`timescale 1ns/1ps
`include "spf_defines.vh"
module spf_top_props (
  input wire        clk_i,
  input wire        arst_n_i,
  input wire [4:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        irq_o,
  input wire        idle_i,
  input wire        sck_o,
  input wire        sck_oe_o,
  input wire        sdo_oe_o,
  input wire        ss_oe_o
);
  reg       on_q;
  reg       halt_q;
  reg       mst_q;
  reg       dsck_q;
  reg       dsdo_q;
  reg [2:0] msk_q;
  wire [2:0] idx = avs_address_i[4:2];
  wire      wr_ok = avs_write_i && !avs_waitrequest_o &&
                    avs_byteenable_i[1:0] == 2'b11;

  // Shadow of control bits; only full-lane writes, as the bench issues
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      on_q   <= 1'b0;
      halt_q <= 1'b0;
      mst_q  <= 1'b0;
      dsck_q <= 1'b0;
      dsdo_q <= 1'b0;
      msk_q  <= 3'h0;
    end
    else if (wr_ok)
    begin
      if (idx == `SPF_IDX_STAT)
      begin
        on_q   <= avs_writedata_i[`SPF_ST_ON];
        halt_q <= avs_writedata_i[`SPF_ST_IDLE_HALT];
      end
      if (idx == `SPF_IDX_CON1)
      begin
        mst_q  <= avs_writedata_i[`SPF_C1_MASTER_SELECT];
        dsck_q <= avs_writedata_i[`SPF_C1_DIS_SCK];
        dsdo_q <= avs_writedata_i[`SPF_C1_DIS_SDO];
      end
      if (idx == `SPF_IDX_IRQ_MSK)
        msk_q <= avs_writedata_i[2:0];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus request not answered in one cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  AST_NO_SPURIOUS: assert property (!(avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without request");
  AST_UPPER_ZERO: assert property (!avs_waitrequest_o && avs_read_i
    |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_UNMAPPED: assert property (!avs_waitrequest_o && avs_read_i &&
    avs_address_i[4:3] == 2'b11 |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped word read nonzero");
  AST_OE_ON: assert property ($rose(on_q) && mst_q && !dsck_q
    |-> ##[0:3] sck_oe_o)
    else $error("clock pin not claimed after enable");
  AST_OFF_QUIET: assert property (!on_q [*3]
    |-> !sck_oe_o && !sdo_oe_o && !ss_oe_o)
    else $error("pin driven while port off");
  AST_DIS_SDO: assert property (dsdo_q [*3] |-> !sdo_oe_o)
    else $error("data out driven while disabled");
  AST_HALT: assert property ((idle_i && halt_q && on_q) [*3]
    |-> $stable(sck_o))
    else $error("serial clock moved in halted idle");
  AST_START: assert property (wr_ok && idx == `SPF_IDX_DATA && on_q &&
    mst_q && !halt_q |-> ##[1:300] $changed(sck_o))
    else $error("master did not start after data write");
  AST_IRQ_MASK: assert property ($rose(irq_o) |-> msk_q != 3'h0)
    else $error("interrupt raised with all sources masked");
endmodule // spf_top_props

bind spf_top spf_top_props i_spf_top_props (.*);

// [tb_spf_top.sv]
// Self-checking bench for the serial port with an echo model
`timescale 1ns/1ps
`include "spf_defines.vh"
module tb_spf_top;
  reg         clk_i    = 1'b0;
  reg         arst_n_i = 1'b0;
  reg  [4:0]  adr      = 5'h00;
  reg         rd       = 1'b0;
  reg         wr       = 1'b0;
  reg  [31:0] wdat     = 32'h0000_0000;
  reg         idle     = 1'b0;
  reg         mck      = 1'b0;
  reg         mss      = 1'b1;
  reg         msdi     = 1'b0;
  wire [31:0] rdat;
  wire [7:0]  peer;
  wire        wt, irq, sck, sck_oe, sdo, sdo_oe, ss, ss_oe, sdi;
  integer     bad_count = 0;
  integer     compares  = 0;
  integer     seed      = 87;
  integer     i, k, n, m, fr;
  reg  [7:0]  prev = 8'h5A;
  reg  [7:0]  b;
  reg  [31:0] got;
  reg  [7:0]  q [$];

  spf_top i_spf_top (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .irq_o(irq),
    .idle_i(idle), .sck_i(mck), .sck_o(sck), .sck_oe_o(sck_oe),
    .sdi_i(mss ? sdi : msdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .ss_i(mss), .ss_o(ss), .ss_oe_o(ss_oe));
  // A released data out reads as the pull-up level at the peer
  spf_peer_model #(.INIT(8'h5A)) i_spf_peer_model (.sck_i(sck),
    .sdo_i(sdo_oe ? sdo : 1'b1), .sdi_o(sdi), .data_o(peer));

  // Clock and watchdog; the watchdog covers the slowest word counts
  initial forever #2.5 clk_i = ~clk_i;
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count = bad_count + 1;
    close_out;
  end

  task chk(input [31:0] seen, input [31:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // One Avalon access, held until waitrequest is seen low
  task bus(input we, input [2:0] idx, input [15:0] d);
  begin
    @(posedge clk_i);
    rd   <= !we;
    wr   <= we;
    adr  <= {idx, 2'b00};
    wdat <= {16'h0000, d};
    n = 0;
    @(posedge clk_i);
    while (wt !== 1'b0 && n < 50)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    got = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    chk(wt, 0);
  end
  endtask

  // Whole-word writes only, never read-modify-write
  task xfer(input [7:0] v, input keep);
  begin
    bus(1, `SPF_IDX_DATA, {8'h00, v});
    if (keep)
      q.push_back(prev);
    prev = v;
  end
  endtask

  task wait_bit(input integer bit_no);
  begin
    m = 0;
    got = 0;
    while (got[bit_no] !== 1'b1 && m < 5000)
    begin
      bus(0, `SPF_IDX_STAT, 16'h0000);
      m = m + 1;
    end
    chk(got[bit_no], 1);
  end
  endtask

  task rd_data;
  begin
    bus(0, `SPF_IDX_DATA, 16'h0000);
    chk(got, {24'h0, q.pop_front()});
  end
  endtask

  task close_out;
  begin
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    // Reset values; word 3 skipped, word 7 is unmapped
    for (i = 0; i < 8; i = i + 1)
      if (i != 3)
      begin
        bus(0, i[2:0], 16'h0000);
        chk(got, (i == 0) ? 32'h0000_00A0 : 32'h0);
      end
    $display("reset values done");
    // One word per primary code; idle without halt keeps running
    idle <= 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      bus(1, `SPF_IDX_STAT, 16'h0000);
      bus(1, `SPF_IDX_CON1, 16'h0020 | ((7 - i) << 2) | (3 - i));
      bus(1, `SPF_IDX_CON2, (i == 1) ? 16'h8000 : 16'h0000);
      bus(1, `SPF_IDX_STAT, 16'h8000);
      b = $random(seed);
      xfer(b, 1);
      m = 0;
      fr = 0;
      while (sck !== 1'b1 && m < 400)
      begin
        @(posedge clk_i);
        m = m + 1;
        fr = fr + (ss === 1'b0);
      end
      k = 0;
      while (sck === 1'b1 && k < 400)
      begin
        @(posedge clk_i);
        k = k + 1;
      end
      chk(k, (i == 0) ? 1 : (4 ** i) * (i + 1) / 2);
      wait_bit(0);
      chk(got & 32'h8043, 32'h8001);
      chk(peer, b);
      // Framed word: select pulse lasts one bit time, eight clocks here
      chk(fr, (i == 1) ? 8 : 0);
      chk({sck_oe, sdo_oe, ss_oe, ss}, (i == 1) ? 4'hF : 4'hD);
      rd_data;
      bus(0, `SPF_IDX_STAT, 16'h0000);
      chk(got & 32'h0001, 0);
      bus(0, `SPF_IDX_IRQ_ST, 16'h0000);
      chk(got, 32'h0005);
      chk(irq, 0);
    end
    $display("divider words done");
    // Halt in idle freezes the port until idle ends
    bus(1, `SPF_IDX_STAT, 16'h0000);
    bus(1, `SPF_IDX_CON1, 16'h083F);
    bus(1, `SPF_IDX_STAT, 16'hA000);
    xfer($random(seed), 1);
    // Data out is switched off, so the peer takes in pull-up ones
    prev = 8'hFF;
    repeat (300) @(posedge clk_i);
    chk(sdo_oe, 0);
    bus(0, `SPF_IDX_STAT, 16'h0000);
    chk(got & 32'h0001, 0);
    idle <= 1'b0;
    wait_bit(0);
    rd_data;
    $display("idle halt done");
    // Eight-entry buffer: fill, refuse, overflow, drain
    bus(1, `SPF_IDX_STAT, 16'h0000);
    bus(1, `SPF_IDX_CON1, 16'h0021);
    bus(1, `SPF_IDX_CON2, 16'h0001);
    bus(1, `SPF_IDX_IRQ_MSK, 16'h0002);
    bus(1, `SPF_IDX_STAT, 16'h8000);
    for (i = 0; i < 9; i = i + 1)
      xfer($random(seed), i < 8);
    bus(1, `SPF_IDX_DATA, 16'h00FF);
    bus(0, `SPF_IDX_STAT, 16'h0000);
    chk(got & 32'h0702, 32'h0702);
    wait_bit(6);
    @(posedge clk_i);
    chk(irq, 1);
    bus(0, `SPF_IDX_STAT, 16'h0000);
    chk(got & 32'h0741, 32'h0041);
    for (i = 0; i < 8; i = i + 1)
      rd_data;
    bus(0, `SPF_IDX_STAT, 16'h0000);
    chk(got & 32'h0021, 32'h0020);
    bus(0, `SPF_IDX_IRQ_ST, 16'h0000);
    chk(got, 32'h0007);
    repeat (2) @(posedge clk_i);
    chk(irq, 0);
    bus(1, `SPF_IDX_STAT, 16'h8000);
    bus(0, `SPF_IDX_STAT, 16'h0000);
    chk(got & 32'h0040, 0);
    $display("buffer fill done");
    // Slave with edge select and select pin; the bench clocks one word
    bus(1, `SPF_IDX_STAT, 16'h0000);
    bus(1, `SPF_IDX_DATA, 16'h0000);
    bus(1, `SPF_IDX_CON1, 16'h0180);
    bus(1, `SPF_IDX_CON2, 16'h0000);
    bus(1, `SPF_IDX_STAT, 16'h8000);
    b = $random(seed);
    got = 32'hFFFF_FFFF;
    mss <= 1'b0;
    for (i = 0; i < 8; i = i + 1)
    begin
      msdi <= b[7 - i];
      repeat (4) @(posedge clk_i);
      got = {got[30:0], sdo};
      mck <= 1'b1;
      repeat (4) @(posedge clk_i);
      mck <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    chk(got, 32'hFFFF_FF00);
    chk(sdo_oe, 1);
    mss <= 1'b1;
    q.push_back(b);
    wait_bit(0);
    rd_data;
    $display("slave word done");
    close_out;
  end
endmodule // tb_spf_top
